// ### shared/sct_pkg.sv
// Package with the constants of the synchronous DRAM command core
package sct_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Array organisation
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int ROWS = 4096;
	localparam int COL_W = 8;
	localparam int COLS = 256;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int MASK_W = 4;
	localparam int MEM_AW = BANK_W + ROW_W + COL_W;
	localparam int WBUF_DEPTH = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Command codes on {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACTIVE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_BURST_STOP = 3'h6;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_LOAD_MODE = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Address bit positions
	localparam int PRECHARGE_OPTION_BIT = 10;
	localparam int MODE_BLEN_LSB = 0;
	localparam int MODE_ORDER_BIT = 3;
	localparam int MODE_LAT_LSB = 4;
	localparam int MODE_SINGLE_WR_BIT = 9;
	localparam logic [2:0] BLEN_FULL_PAGE = 3'h7;
	localparam logic [ADDR_W-1:0] MODE_RESET = 12'h030;

	////////////////////////////////////////////////////////////////////////////////
	// Timing in clocks
	localparam int MAX_LATENCY = 3;
	localparam int COLUMN_TO_COLUMN_GAP = 1;
	localparam int CKE_ENTRY_DELAY = 1;
	localparam int CKE_EXIT_DELAY = 1;
	localparam int WRITE_MASK_DELAY = 0;
	localparam int READ_MASK_TURNOFF_DELAY = 2;
	localparam int WRITE_CMD_TO_DATA = 0;
	localparam int WRITE_DATA_TO_CLOSE_GAP = 3;
	localparam int LAST_WRITE_TO_CLOSE_GAP = 2;
	localparam int LAST_WRITE_TO_STOP_GAP = 1;
	localparam int LAST_WRITE_TO_COLUMN_GAP = 1;
	localparam int MODE_LOAD_SETTLE_GAP = 2;
	localparam int WRITE_DATA_TO_ACTIVATE_GAP_L3 = 5;
	localparam int WRITE_DATA_TO_ACTIVATE_GAP_L2 = 4;
	localparam int WRITE_DATA_TO_ACTIVATE_GAP_L1 = 3;
	localparam int POWER_UP_WAIT_US = 100;
	localparam int CLK_MHZ = 250;
	localparam int POWER_UP_WAIT_CYCLES = POWER_UP_WAIT_US * CLK_MHZ;
endpackage

// ### design/sct_fifo.sv
// Write buffer between the data pins and the storage array
`timescale 1ns/1ps
module sct_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} sct_fifo_state_t;

	sct_fifo_state_t st;
	sct_fifo_state_t next_st;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////////////
	assign in_ready_o = (st.cnt != FULL);
	assign out_valid_o = (st.cnt != '0);
	assign out_data_o = st.mem[st.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data_i;
			next_st.wp = (st.wp == LAST) ? '0 : st.wp + 1'b1;
		end
		if (pop) begin
			next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
		end
		if (push && !pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (pop && !push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ### design/sct_store.sv
// Storage array with byte-lane writes and a combinational read port
`timescale 1ns/1ps
module sct_store #(
	parameter int AW = sct_pkg::MEM_AW,
	parameter int DW = sct_pkg::DATA_W,
	parameter int NB = sct_pkg::MASK_W
) (
	input wire logic mclk_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [NB-1:0] wbe_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	localparam int LW = DW / NB;

	logic [DW-1:0] mem [2**AW];

	assign rdata_o = mem[raddr_i];

	always_ff @(posedge mclk_i) begin
		for (int b = 0; b < NB; b++) begin
			if (wr_en_i && wbe_i[b]) begin
				mem[waddr_i][b*LW +: LW] <= wdata_i[b*LW +: LW];
			end
		end
	end
endmodule

// ### design/sct_core.sv
// Command decoder, burst engine and data path of the quad-bank synchronous DRAM
// Function
// - Column commands are accepted on consecutive clocks, truncating the running burst.
// - Clock enable sampled low suspends the internal clock from the next cycle.
// - Clock enable sampled high resumes operation one cycle later.
// - Write byte mask applies to the data of the same cycle; masked bytes unwritten.
// - Read byte mask sampled high turns its lane off two cycles later.
// - First write word is taken in the cycle of the write command.
// - Closing the bank of a read stops data after the read latency.
// - Four banks of 4096 rows by 256 columns of 32-bit words.
// - ACTIVE uses bank select and twelve address bits as the row.
// - Column commands take the starting column from the low eight address bits.
// - Each access is a burst of programmed length and order from the start column; writes single with mode bit 9 set, full page always sequential.
// - All command, address, mask and data inputs are sampled on the rising edge.
// - Precharge option bit high closes all banks, low closes the selected bank.
`timescale 1ns/1ps
module sct_core #(
	parameter int WBUF_DEPTH = sct_pkg::WBUF_DEPTH
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [sct_pkg::BANK_W-1:0] ba_i,
	input wire logic [sct_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sct_pkg::MASK_W-1:0] dqm_i,
	input wire logic [sct_pkg::DATA_W-1:0] dq_i,
	output logic [sct_pkg::DATA_W-1:0] dq_o,
	output logic [sct_pkg::MASK_W-1:0] dq_oe_n_o,
	output logic wbuf_ready_o,
	output logic power_down_o,
	output logic [sct_pkg::BANKS-1:0] bank_open_o
);
	localparam int MW = sct_pkg::MASK_W;
	localparam int DW = sct_pkg::DATA_W;
	localparam int AW = sct_pkg::MEM_AW;
	localparam int CW = sct_pkg::COL_W;
	localparam int LW = DW / MW;
	localparam int WB_W = AW + MW + DW;
	localparam int QD = sct_pkg::READ_MASK_TURNOFF_DELAY;
	localparam int ML = sct_pkg::MAX_LATENCY;

	typedef enum logic [1:0] {SCT_IDLE, SCT_READ, SCT_WRITE} sct_burst_t;

	typedef struct packed {
		logic cke_q;
		logic power_down;
		logic [sct_pkg::ADDR_W-1:0] mode;
		logic [sct_pkg::BANKS-1:0] open;
		logic [sct_pkg::BANKS-1:0][sct_pkg::ROW_W-1:0] row;
		sct_burst_t burst;
		logic [sct_pkg::BANK_W-1:0] bank;
		logic [CW-1:0] start;
		logic [CW-1:0] cnt;
		logic [2:0] code;
		logic order;
		logic auto_close;
		logic [ML-1:0] rd_valid;
		logic [ML-1:0][DW-1:0] rd_data;
		logic [QD-1:0][MW-1:0] dqm_pipe;
	} sct_core_state_t;

	sct_core_state_t st;
	sct_core_state_t next_st;
	logic [2:0] cmd;
	logic active;
	logic col_valid;
	logic col_write;
	logic [sct_pkg::BANK_W-1:0] col_bank;
	logic [CW-1:0] col_addr;
	logic [AW-1:0] col_mem;
	logic [1:0] read_latency_setting;
	logic [2:0] new_code;
	logic push_valid;
	logic push_ready;
	logic head_valid;
	logic head_ready;
	logic [WB_W-1:0] push_word;
	logic [WB_W-1:0] head_word;
	logic [DW-1:0] array_word;
	logic [DW-1:0] read_word;

	////////////////////////////////////////////////////////////////////////////////
	// Burst address helpers
	function automatic logic [CW-1:0] burst_mask(input logic [2:0] code);
		case (code)
			3'h1: burst_mask = 8'h01;
			3'h2: burst_mask = 8'h03;
			3'h3: burst_mask = 8'h07;
			sct_pkg::BLEN_FULL_PAGE: burst_mask = 8'hFF;
			default: burst_mask = 8'h00;
		endcase
	endfunction

	function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] start,
		input logic [CW-1:0] cnt, input logic [2:0] code, input logic order);
		logic [CW-1:0] m;
		logic [CW-1:0] off;
		m = burst_mask(code);
		off = (order && code != sct_pkg::BLEN_FULL_PAGE) ? (start ^ cnt) : CW'(start + cnt);
		burst_col = (start & ~m) | (off & m);
	endfunction

	function automatic logic burst_last(input logic [2:0] code, input logic [CW-1:0] cnt);
		burst_last = (code != sct_pkg::BLEN_FULL_PAGE) && (cnt == burst_mask(code));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Read latency and write buffer
	always_comb begin
		case (st.mode[sct_pkg::MODE_LAT_LSB +: 3])
			3'h1: read_latency_setting = 2'h1;
			3'h2: read_latency_setting = 2'h2;
			default: read_latency_setting = 2'h3;
		endcase
	end

	assign col_mem = {col_bank, st.row[col_bank], col_addr};
	assign push_word = {col_mem, ~dqm_i, dq_i};
	assign push_valid = active && col_valid && col_write && (|(~dqm_i));
	assign head_ready = active && !(col_valid && !col_write);
	assign new_code = (cmd == sct_pkg::CMD_WRITE && st.mode[sct_pkg::MODE_SINGLE_WR_BIT]) ?
		3'h0 : st.mode[sct_pkg::MODE_BLEN_LSB +: 3];

	sct_fifo #(
		.W(WB_W),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_word),
		.out_valid_o(head_valid),
		.out_ready_i(head_ready),
		.out_data_o(head_word)
	);

	sct_store #(
		.AW(AW),
		.DW(DW),
		.NB(MW)
	) u_store (
		.mclk_i(mclk_i),
		.wr_en_i(head_valid && head_ready),
		.waddr_i(head_word[WB_W-1 -: AW]),
		.wbe_i(head_word[DW +: MW]),
		.wdata_i(head_word[DW-1:0]),
		.raddr_i(col_mem),
		.rdata_o(array_word)
	);

	// Pending buffered bytes override the array so reads see the newest data
	always_comb begin
		read_word = array_word;
		for (int b = 0; b < MW; b++) begin
			if (head_valid && head_word[WB_W-1 -: AW] == col_mem && head_word[DW + b]) begin
				read_word[b*LW +: LW] = head_word[b*LW +: LW];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode and burst engine
	always_comb begin
		next_st = st;
		cmd = {ras_n_i, cas_n_i, we_n_i};
		active = st.cke_q;
		col_valid = 1'b0;
		col_write = (st.burst == SCT_WRITE);
		col_bank = st.bank;
		col_addr = burst_col(st.start, st.cnt, st.code, st.order);
		next_st.cke_q = cke_i;
		if (!active) begin
			next_st.power_down = (st.burst == SCT_IDLE);
		end else begin
			next_st.power_down = 1'b0;
			for (int i = QD - 1; i > 0; i--) begin
				next_st.dqm_pipe[i] = st.dqm_pipe[i-1];
			end
			next_st.dqm_pipe[0] = dqm_i;
			for (int i = 0; i < ML - 1; i++) begin
				next_st.rd_valid[i] = st.rd_valid[i+1];
				next_st.rd_data[i] = st.rd_data[i+1];
			end
			next_st.rd_valid[ML-1] = 1'b0;
			if (st.burst != SCT_IDLE) begin
				col_valid = st.open[st.bank];
				next_st.cnt = st.cnt + 8'h01;
				if (burst_last(st.code, st.cnt)) begin
					next_st.burst = SCT_IDLE;
					if (st.auto_close) begin
						next_st.open[st.bank] = 1'b0;
					end
				end
			end
			if (!cs_n_i) begin
				case (cmd)
					sct_pkg::CMD_ACTIVE: begin
						next_st.open[ba_i] = 1'b1;
						next_st.row[ba_i] = addr_i;
					end
					sct_pkg::CMD_READ, sct_pkg::CMD_WRITE: begin
						col_valid = st.open[ba_i];
						col_write = (cmd == sct_pkg::CMD_WRITE);
						col_bank = ba_i;
						col_addr = addr_i[CW-1:0];
						next_st.bank = ba_i;
						next_st.start = addr_i[CW-1:0];
						next_st.cnt = 8'h01;
						next_st.code = new_code;
						next_st.order = st.mode[sct_pkg::MODE_ORDER_BIT];
						next_st.auto_close = addr_i[sct_pkg::PRECHARGE_OPTION_BIT];
						next_st.burst = col_write ? SCT_WRITE : SCT_READ;
						if (burst_last(new_code, 8'h00)) begin
							next_st.burst = SCT_IDLE;
							if (addr_i[sct_pkg::PRECHARGE_OPTION_BIT]) begin
								next_st.open[ba_i] = 1'b0;
							end
						end
					end
					sct_pkg::CMD_BURST_STOP: begin
						col_valid = 1'b0;
						next_st.burst = SCT_IDLE;
					end
					sct_pkg::CMD_PRECHARGE: begin
						if (addr_i[sct_pkg::PRECHARGE_OPTION_BIT]) begin
							next_st.open = '0;
						end else begin
							next_st.open[ba_i] = 1'b0;
						end
						if (addr_i[sct_pkg::PRECHARGE_OPTION_BIT] || ba_i == st.bank) begin
							col_valid = 1'b0;
							next_st.burst = SCT_IDLE;
						end
					end
					sct_pkg::CMD_LOAD_MODE: begin
						next_st.mode = addr_i;
					end
					default: begin
					end
				endcase
			end
			if (col_valid && !col_write) begin
				next_st.rd_valid[read_latency_setting - 2'h1] = 1'b1;
				next_st.rd_data[read_latency_setting - 2'h1] = read_word;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '0;
			st.mode <= sct_pkg::MODE_RESET;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin outputs
	assign dq_o = st.rd_data[0];
	assign dq_oe_n_o = ~({MW{st.rd_valid[0]}} & ~st.dqm_pipe[QD-1]);
	assign wbuf_ready_o = push_ready;
	assign power_down_o = st.power_down;
	assign bank_open_o = st.open;
endmodule

// ### sim/sct_core_props.sv
// Timing checker of the DRAM command core
`timescale 1ns/1ps
module sct_core_props (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] ba_i,
	input wire logic [11:0] addr_i,
	input wire logic [3:0] dqm_i,
	input wire logic [3:0] dq_oe_n_o,
	input wire logic power_down_o,
	input wire logic [3:0] bank_open_o
);
	logic en_q;
	logic [2:0] cmd;
	logic take;
	assign cmd = {ras_n_i, cas_n_i, we_n_i};
	assign take = en_q && !cs_n_i;
	always_ff @(posedge mclk_i) begin
		en_q <= cke_i && !srst_i;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////////////////////
	chk_row_open: assert property (
		take && cmd == sct_pkg::CMD_ACTIVE |=> bank_open_o[$past(ba_i)])
		else $error("active left the bank closed");
	chk_close_all: assert property (
		take && cmd == sct_pkg::CMD_PRECHARGE && addr_i[10] |=> bank_open_o == 4'h0)
		else $error("close all left a bank open");
	chk_close_one: assert property (
		take && cmd == sct_pkg::CMD_PRECHARGE && !addr_i[10] |=> !bank_open_o[$past(ba_i)])
		else $error("close left the bank open");
	chk_mask_off: assert property (
		$past(en_q, 1) && $past(en_q, 2)
		|-> (~dq_oe_n_o & $past(dqm_i, 2)) == 4'h0)
		else $error("masked lane driven");
	chk_sleep_gate: assert property (
		power_down_o |-> !en_q || !$past(en_q))
		else $error("power down while clock enabled");
	chk_awake_run: assert property (
		en_q [*3] |-> !power_down_o)
		else $error("power down after clock enable returned");
	chk_frozen_banks: assert property (
		!en_q |=> $stable(bank_open_o))
		else $error("bank state moved while frozen");
	chk_close_quiet: assert property (
		take && cmd == sct_pkg::CMD_PRECHARGE && addr_i[10]
		##1 (en_q && (cs_n_i || cmd != sct_pkg::CMD_READ)) [*4] |-> dq_oe_n_o == 4'hF)
		else $error("data still driven after close");
	cover property (take && cmd == sct_pkg::CMD_READ);
	cover property (power_down_o);
	cover property (take && cmd == sct_pkg::CMD_PRECHARGE && !addr_i[10]);
endmodule
bind sct_core sct_core_props u_props (
	.mclk_i(mclk_i), .srst_i(srst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
	.ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i),
	.addr_i(addr_i), .dqm_i(dqm_i), .dq_oe_n_o(dq_oe_n_o),
	.power_down_o(power_down_o), .bank_open_o(bank_open_o)
);

// ### sim/sct_ctrl_model.sv
// Behavioural memory controller driving the command and data pins
`timescale 1ns/1ps
module sct_ctrl_model (
	input wire logic mclk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] cmd_o,
	output logic [1:0] ba_o,
	output logic [11:0] addr_o,
	output logic [3:0] dqm_o,
	output logic [31:0] dq_o
);
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		cmd_o = sct_pkg::CMD_NOP;
		ba_o = 2'h0;
		addr_o = 12'h000;
		dqm_o = 4'h0;
		dq_o = 32'h0;
	end
	task automatic issue(input logic [2:0] code, input logic [1:0] ba, input logic [11:0] addr,
		input logic [3:0] dqm, input logic [31:0] d);
		@(posedge mclk_i);
		cs_n_o <= 1'b0;
		cmd_o <= code;
		ba_o <= ba;
		addr_o <= addr;
		dqm_o <= dqm;
		dq_o <= d;
	endtask
	// Wait cycles carry no-operation, with released lines flipping
	task automatic idle(input int n);
		repeat (n) issue(sct_pkg::CMD_NOP, ~ba_o, ~addr_o, 4'h0, ~dq_o);
	endtask
	task automatic set_cke(input logic v);
		@(posedge mclk_i);
		cke_o <= v;
	endtask
	task automatic power_up(input int wait_cycles, input logic [11:0] mode);
		idle(wait_cycles);
		issue(sct_pkg::CMD_PRECHARGE, ~ba_o, ~addr_o | 12'h400, 4'h0, ~dq_o);
		idle(4);
		repeat (2) begin
			issue(sct_pkg::CMD_REFRESH, ~ba_o, ~addr_o, 4'h0, ~dq_o);
			idle(16);
		end
		issue(sct_pkg::CMD_LOAD_MODE, ~ba_o, mode, 4'h0, ~dq_o);
		idle(2);
	endtask
endmodule

// ### sim/tb_sdram_command_timing_core.sv
// Testbench of the DRAM command core against a behavioural array model
`timescale 1ns/1ps
`define CHECK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_sdram_command_timing_core;
	logic mclk;
	logic srst;
	logic cke;
	logic cs_n;
	logic [2:0] cmd;
	logic [1:0] ba;
	logic [11:0] addr;
	logic [3:0] dqm;
	logic [31:0] dq_in;
	logic [31:0] dq_out;
	logic [3:0] oe_n;
	logic pd;
	logic [3:0] open;
	int num_errors;
	int compares;
	int seed;
	logic [31:0] mem [int];
	logic [1:0] b;
	logic [7:0] c;
	logic [7:0] c2;
	logic [31:0] w;
	logic [11:0] row [4];
	logic wbuf_ready;
	sct_core dut (.mclk_i(mclk), .srst_i(srst), .cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr),
		.dqm_i(dqm), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_n_o(oe_n),
		.wbuf_ready_o(wbuf_ready),
		.power_down_o(pd), .bank_open_o(open));
	sct_ctrl_model ctrl (.mclk_i(mclk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .ba_o(ba),
		.addr_o(addr), .dqm_o(dqm), .dq_o(dq_in));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic int key(input logic [1:0] bk, input logic [7:0] col);
		return int'({bk, col});
	endfunction
	function automatic logic [31:0] lanes(input logic [3:0] mk);
		return {{8{mk[3]}}, {8{mk[2]}}, {8{mk[1]}}, {8{mk[0]}}};
	endfunction
	task automatic see(input logic [3:0] eoe, input logic [31:0] word);
		ctrl.idle(1);
		#1;
		`CHECK("dq_oe_n_o", eoe, oe_n)
		`CHECK("dq_o", word & ~lanes(eoe), dq_out & ~lanes(eoe))
	endtask
	task automatic wr(input logic [3:0] mk);
		logic [31:0] d0;
		logic [31:0] d1;
		d0 = $random(seed);
		d1 = $random(seed);
		ctrl.issue(sct_pkg::CMD_WRITE, b, {4'h0, c}, 4'h0, d0);
		ctrl.issue(sct_pkg::CMD_NOP, b, 12'($random(seed)), mk, d1);
		mem[key(b, c)] = d0;
		mem[key(b, c ^ 8'h01)] = (mem[key(b, c ^ 8'h01)] & lanes(mk)) | (d1 & ~lanes(mk));
		ctrl.idle(3);
		#1;
		`CHECK("wbuf_ready_o", 1'b1, wbuf_ready)
	endtask
	task automatic rd(input logic [3:0] mk);
		ctrl.issue(sct_pkg::CMD_READ, b, {4'h0, c}, mk, ~dq_in);
		ctrl.idle(1);
		see(mk, mem[key(b, c)]);
		see(4'h0, mem[key(b, c ^ 8'h01)]);
		see(4'hF, 32'h0);
	endtask
	task automatic print_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge mclk);
		num_errors++;
		print_verdict();
	end
	initial begin
		seed = 47805;
		num_errors = 0;
		compares = 0;
		srst = 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		#1;
		`CHECK("dq_oe_n_o", 4'hF, oe_n)
		ctrl.power_up(sct_pkg::POWER_UP_WAIT_CYCLES, 12'h021);
		for (int i = 0; i < 4; i++) begin
			row[i] = 12'($random(seed));
			ctrl.issue(sct_pkg::CMD_ACTIVE, 2'(i), row[i], 4'($random(seed)), ~dq_in);
			ctrl.idle(2);
		end
		#1;
		`CHECK("bank_open_o", 4'hF, open)
		repeat (6) begin
			b = 2'($random(seed));
			c = 8'($random(seed));
			wr(4'h0);
			wr(4'($random(seed)));
			rd(4'($random(seed)));
		end
		c = c ^ 8'h80;
		wr(4'h0);
		c2 = c;
		c = c ^ 8'h80;
		ctrl.issue(sct_pkg::CMD_READ, b, {4'h0, c}, 4'h0, ~dq_in);
		ctrl.issue(sct_pkg::CMD_READ, b, {4'h0, c2}, 4'h0, ~dq_in);
		see(4'h0, mem[key(b, c)]);
		see(4'h0, mem[key(b, c2)]);
		see(4'h0, mem[key(b, c2 ^ 8'h01)]);
		see(4'hF, 32'h0);
		// Stopped write burst leaves the second column unwritten
		w = $random(seed);
		ctrl.issue(sct_pkg::CMD_WRITE, b, {4'h0, c}, 4'h0, w);
		ctrl.issue(sct_pkg::CMD_BURST_STOP, b, 12'($random(seed)), 4'($random(seed)), ~w);
		mem[key(b, c)] = w;
		ctrl.idle(3);
		rd(4'h0);
		// Auto-close write, then reopen after the recovery gap
		w = $random(seed);
		ctrl.issue(sct_pkg::CMD_WRITE, b, {4'h4, c}, 4'h0, w);
		ctrl.issue(sct_pkg::CMD_NOP, b, 12'($random(seed)), 4'h0, ~w);
		mem[key(b, c)] = w;
		mem[key(b, c ^ 8'h01)] = ~w;
		ctrl.idle(3);
		#1;
		`CHECK("bank_open_o", 1'b0, open[b])
		ctrl.issue(sct_pkg::CMD_ACTIVE, b, row[b], 4'($random(seed)), ~dq_in);
		ctrl.idle(2);
		rd(4'h0);
		ctrl.issue(sct_pkg::CMD_READ, b, {4'h0, c}, 4'h0, ~dq_in);
		ctrl.issue(sct_pkg::CMD_PRECHARGE, b, 12'($random(seed)) & 12'hBFF,
			4'($random(seed)), ~dq_in);
		see(4'h0, mem[key(b, c)]);
		see(4'hF, 32'h0);
		`CHECK("bank_open_o", 1'b0, open[b])
		ctrl.set_cke(1'b0);
		ctrl.idle(3);
		ctrl.issue(sct_pkg::CMD_ACTIVE, b, row[b], 4'($random(seed)), ~dq_in);
		ctrl.idle(2);
		#1;
		`CHECK("power_down_o", 1'b1, pd)
		`CHECK("bank_open_o", 1'b0, open[b])
		ctrl.set_cke(1'b1);
		ctrl.issue(sct_pkg::CMD_ACTIVE, b, row[b], 4'($random(seed)), ~dq_in);
		ctrl.idle(2);
		#1;
		`CHECK("power_down_o", 1'b0, pd)
		`CHECK("bank_open_o", 1'b1, open[b])
		ctrl.issue(sct_pkg::CMD_READ, b, {4'h0, c}, 4'h0, ~dq_in);
		ctrl.issue(sct_pkg::CMD_PRECHARGE, b, 12'($random(seed)) | 12'h400,
			4'($random(seed)), ~dq_in);
		ctrl.idle(5);
		#1;
		`CHECK("bank_open_o", 4'h0, open)
		print_verdict();
	end
endmodule
